// ---- rtl/fsw_pkg.sv ----
// package: status word layout, opcode table and helper decode functions
package fsw_pkg;

   // ----------------------------------------------------------------
   // status word layout
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       status_lock_bit;
      logic       quad_lines_enable;
      logic [3:0] block_protect;
      logic       write_enable_latch;
      logic       busy_flag;
   } fsw_status_s;

   localparam int          BUSY_FLAG_POS    = 0;
   localparam int          WEL_POS          = 1;
   localparam int          BLOCK_PROT_LSB   = 2;
   localparam int          BLOCK_PROT_MSB   = 5;
   localparam int          QUAD_ENABLE_POS  = 6;
   localparam int          STATUS_LOCK_POS  = 7;
   localparam logic [7:0]  STATUS_RESET     = 8'h00;
   localparam logic [3:0]  BLOCK_PROT_NONE  = 4'h0;
   localparam int          SYNC_STAGES      = 2;

   // ----------------------------------------------------------------
   // opcodes that need the write enable latch, then the suspend opcode that does not
   // ----------------------------------------------------------------
   localparam logic [7:0] PAGE_PROGRAM_CMD               = 8'h02;
   localparam logic [7:0] PAGE_PROGRAM_LONG_ADDR_CMD     = 8'h12;
   localparam logic [7:0] QUAD_PAGE_PROGRAM_CMD_A        = 8'h32;
   localparam logic [7:0] QUAD_PAGE_PROGRAM_CMD_B        = 8'h38;
   localparam logic [7:0] QUAD_PAGE_PROGRAM_LONG_A       = 8'h34;
   localparam logic [7:0] QUAD_PAGE_PROGRAM_LONG_B       = 8'h3e;
   localparam logic [7:0] SMALL_ERASE_CMD_A              = 8'hd7;
   localparam logic [7:0] SMALL_ERASE_CMD_B              = 8'h20;
   localparam logic [7:0] SMALL_ERASE_LONG_ADDR_CMD      = 8'h21;
   localparam logic [7:0] HALF_BLOCK_ERASE_CMD           = 8'h52;
   localparam logic [7:0] HALF_BLOCK_ERASE_LONG_ADDR_CMD = 8'h5c;
   localparam logic [7:0] FULL_BLOCK_ERASE_CMD           = 8'hd8;
   localparam logic [7:0] FULL_BLOCK_ERASE_LONG_ADDR_CMD = 8'hdc;
   localparam logic [7:0] WHOLE_ARRAY_ERASE_CMD_A        = 8'hc7;
   localparam logic [7:0] WHOLE_ARRAY_ERASE_CMD_B        = 8'h60;
   localparam logic [7:0] STATUS_WRITE_CMD               = 8'h01;
   localparam logic [7:0] FUNCTION_WORD_WRITE_CMD        = 8'h42;
   localparam logic [7:0] NV_READ_PARAMS_CMD             = 8'h65;
   localparam logic [7:0] NV_EXTENDED_READ_PARAMS_CMD    = 8'h85;
   localparam logic [7:0] INFO_ROW_ERASE_CMD             = 8'h64;
   localparam logic [7:0] INFO_ROW_PROGRAM_CMD           = 8'h62;
   localparam logic [7:0] AUTOBOOT_WRITE_CMD             = 8'h15;
   localparam logic [7:0] NV_BANK_ADDRESS_WRITE_CMD      = 8'h18;
   localparam logic [7:0] PERSISTENT_LOCK_WRITE_CMD      = 8'hfd;
   localparam logic [7:0] PERSISTENT_LOCK_WRITE_LONG_CMD = 8'he3;
   localparam logic [7:0] PERSISTENT_LOCK_ERASE_CMD      = 8'he4;
   localparam logic [7:0] PROTECTION_MODE_PROGRAM_CMD    = 8'h2f;
   localparam logic [7:0] LOCK_BIT_WRITE_CMD             = 8'ha6;
   localparam logic [7:0] FREEZE_SET_CMD                 = 8'h91;
   localparam logic [7:0] PASSWORD_PROGRAM_CMD           = 8'he8;
   // suspend accepted during a running program or erase
   localparam logic [7:0] OP_SUSPEND_CMD                 = 8'h75;

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   function automatic logic fsw_needs_wel(input logic [7:0] op);
      case (op)
         PAGE_PROGRAM_CMD, PAGE_PROGRAM_LONG_ADDR_CMD, QUAD_PAGE_PROGRAM_CMD_A,
         QUAD_PAGE_PROGRAM_CMD_B, QUAD_PAGE_PROGRAM_LONG_A, QUAD_PAGE_PROGRAM_LONG_B,
         SMALL_ERASE_CMD_A, SMALL_ERASE_CMD_B, SMALL_ERASE_LONG_ADDR_CMD,
         HALF_BLOCK_ERASE_CMD, HALF_BLOCK_ERASE_LONG_ADDR_CMD, FULL_BLOCK_ERASE_CMD,
         FULL_BLOCK_ERASE_LONG_ADDR_CMD, WHOLE_ARRAY_ERASE_CMD_A,
         WHOLE_ARRAY_ERASE_CMD_B, STATUS_WRITE_CMD, FUNCTION_WORD_WRITE_CMD,
         NV_READ_PARAMS_CMD, NV_EXTENDED_READ_PARAMS_CMD, INFO_ROW_ERASE_CMD,
         INFO_ROW_PROGRAM_CMD, AUTOBOOT_WRITE_CMD, NV_BANK_ADDRESS_WRITE_CMD,
         PERSISTENT_LOCK_WRITE_CMD, PERSISTENT_LOCK_WRITE_LONG_CMD,
         PERSISTENT_LOCK_ERASE_CMD, PROTECTION_MODE_PROGRAM_CMD, LOCK_BIT_WRITE_CMD,
         FREEZE_SET_CMD, PASSWORD_PROGRAM_CMD:
            fsw_needs_wel = 1'b1;
         default:
            fsw_needs_wel = 1'b0;
      endcase
   endfunction

   function automatic logic fsw_is_chip_erase(input logic [7:0] op);
      fsw_is_chip_erase = (op == WHOLE_ARRAY_ERASE_CMD_A) || (op == WHOLE_ARRAY_ERASE_CMD_B);
   endfunction

endpackage

// ---- rtl/fsw_status_write_enable.sv ----
// status word, write enable latch and instruction gating for a serial flash
`timescale 1ns/1ps
module fsw_status_write_enable
   import fsw_pkg::*;
#(
   parameter logic [7:0] STATUS_READ_OP = 8'h05,
   parameter logic [7:0] EXT_READ_OP    = 8'h81,
   parameter logic [7:0] SET_WEL_OP     = 8'h06,
   parameter logic [7:0] CLEAR_WEL_OP   = 8'h04,
   parameter logic [7:0] SOFT_RESET_OP  = 8'h99
)
(
   input  wire logic       CLK_SYS,
   input  wire logic       RST,
   input  wire logic       CS_N,
   input  wire logic       SCK,
   input  wire logic       SI,
   input  wire logic       WP_N,
   input  wire logic       OP_DONE,
   output logic            SO,
   output logic            SO_OE,
   output logic            OP_START,
   output logic [7:0]      OP_CODE,
   output logic            OP_SUSPEND,
   output logic            OP_ABORT,
   output logic            QUAD_LINES_ON,
   output logic [7:0]      STATUS
);

   // ----------------------------------------------------------------
   // types and elaboration checks
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_OPC  = 2'b01,
      ST_ARG  = 2'b11,
      ST_IGN  = 2'b10
   } fsw_state_e;

   initial
   begin
      if (STATUS_READ_OP == SET_WEL_OP || SET_WEL_OP == CLEAR_WEL_OP ||
          fsw_needs_wel(SET_WEL_OP) || fsw_needs_wel(STATUS_READ_OP))
      begin
         $error("fsw_status_write_enable: opcode parameters collide");
      end
   end

   // ----------------------------------------------------------------
   // pin synchronisers and edge detection
   // ----------------------------------------------------------------
   logic [3:0] pins_s;
   logic       cs_n_s;
   logic       sck_s;
   logic       si_s;
   logic       wp_n_s;

   fsw_sync #(
      .WIDTH     (4),
      .RESET_VAL (4'h9)
   ) u_sync (
      .clk      (CLK_SYS),
      .rst      (RST),
      .async_in ({CS_N, SCK, SI, WP_N}),
      .sync_out (pins_s)
   );

   assign cs_n_s = pins_s[3];
   assign sck_s  = pins_s[2];
   assign si_s   = pins_s[1];
   assign wp_n_s = pins_s[0];

   logic sck_prev_q;
   logic cs_prev_q;
   logic sck_rise;
   logic sck_fall;
   logic cs_rise;

   assign sck_rise = !cs_n_s && sck_s && !sck_prev_q;
   assign sck_fall = !cs_n_s && !sck_s && sck_prev_q;
   assign cs_rise  = cs_n_s && !cs_prev_q;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   fsw_state_e  state_q,    state_d;
   logic [2:0]  bitcnt_q,   bitcnt_d;
   logic [7:0]  shift_q,    shift_d;
   logic [7:0]  opc_q,      opc_d;
   logic [7:0]  data_q,     data_d;
   logic [1:0]  nbytes_q,   nbytes_d;
   logic [7:0]  out_q,      out_d;
   fsw_status_s stat_q,     stat_d;
   logic        so_q,       so_d;
   logic        so_oe_q,    so_oe_d;
   logic        start_q,    start_d;
   logic [7:0]  code_q,     code_d;
   logic        susp_q,     susp_d;
   logic        abort_q,    abort_d;

   logic [7:0]  byte_in;
   logic        allowed_busy;
   logic        status_locked;
   logic        wel_ok;

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always_comb
   begin
      state_d  = state_q;
      bitcnt_d = bitcnt_q;
      shift_d  = shift_q;
      opc_d    = opc_q;
      data_d   = data_q;
      nbytes_d = nbytes_q;
      out_d    = out_q;
      stat_d   = stat_q;
      so_d     = so_q;
      start_d  = 1'b0;
      code_d   = code_q;
      susp_d   = 1'b0;
      abort_d  = 1'b0;
      byte_in  = {shift_q[6:0], si_s};

      // reads, reset and suspend pass while busy
      allowed_busy = (byte_in == STATUS_READ_OP) || (byte_in == EXT_READ_OP) ||
                     (byte_in == SOFT_RESET_OP)  || (byte_in == OP_SUSPEND_CMD);
      // protect pin only acts while it is not a data line
      status_locked = stat_q.status_lock_bit && !wp_n_s &&
                      !stat_q.quad_lines_enable;
      wel_ok = stat_q.write_enable_latch;

      // operation end clears busy and the latch
      if (OP_DONE && stat_q.busy_flag)
      begin
         stat_d.busy_flag          = 1'b0;
         stat_d.write_enable_latch = 1'b0;
      end

      if (cs_n_s)
      begin
         state_d  = ST_IDLE;
         bitcnt_d = 3'h0;
         nbytes_d = 2'h0;
      end
      else if (state_q == ST_IDLE)
      begin
         state_d  = ST_OPC;
         bitcnt_d = 3'h0;
      end

      if (sck_rise && (state_q == ST_OPC || state_q == ST_ARG))
      begin
         shift_d  = byte_in;
         bitcnt_d = bitcnt_q + 3'h1;
         if (bitcnt_q == 3'h7)
         begin
            out_d = stat_d;
            if (state_q == ST_OPC)
            begin
               opc_d = byte_in;
               state_d = (stat_q.busy_flag && !allowed_busy) ? ST_IGN : ST_ARG;
            end
            else
            begin
               if (nbytes_q == 2'h0)
               begin
                  data_d = byte_in;
               end
               if (nbytes_q != 2'h3)
               begin
                  nbytes_d = nbytes_q + 2'h1;
               end
            end
         end
      end

      if (sck_fall && state_q == ST_ARG && opc_q == STATUS_READ_OP)
      begin
         so_d = out_q[3'h7 - bitcnt_q];
      end

      // instructions take effect at deselect on a byte boundary
      if (cs_rise && state_q == ST_ARG && bitcnt_q == 3'h0)
      begin
         if (opc_q == SOFT_RESET_OP)
         begin
            stat_d.busy_flag          = 1'b0;
            stat_d.write_enable_latch = 1'b0;
            abort_d                   = 1'b1;
         end
         else if (opc_q == OP_SUSPEND_CMD)
         begin
            susp_d = stat_q.busy_flag;
         end
         else if (opc_q == STATUS_READ_OP || opc_q == EXT_READ_OP)
         begin
            stat_d = stat_d;
         end
         else if (opc_q == SET_WEL_OP)
         begin
            stat_d.write_enable_latch = 1'b1;
         end
         else if (opc_q == CLEAR_WEL_OP)
         begin
            stat_d.write_enable_latch = 1'b0;
         end
         else if (fsw_needs_wel(opc_q))
         begin
            // a rejected instruction leaves every stored bit alone
            if (!wel_ok)
            begin
               stat_d = stat_d;
            end
            else if (opc_q == STATUS_WRITE_CMD)
            begin
               if (nbytes_q != 2'h0 && !status_locked)
               begin
                  stat_d.block_protect     = data_q[BLOCK_PROT_MSB:BLOCK_PROT_LSB];
                  stat_d.quad_lines_enable = data_q[QUAD_ENABLE_POS];
                  stat_d.status_lock_bit   = data_q[STATUS_LOCK_POS];
                  stat_d.busy_flag         = 1'b1;
                  start_d                  = 1'b1;
                  code_d                   = opc_q;
               end
            end
            else if (fsw_is_chip_erase(opc_q) && stat_q.block_protect != BLOCK_PROT_NONE)
            begin
               stat_d = stat_d;
            end
            else
            begin
               stat_d.busy_flag = 1'b1;
               start_d          = 1'b1;
               code_d           = opc_q;
            end
         end
         else
         begin
            // volatile and other commands pass on without busy
            start_d = 1'b1;
            code_d  = opc_q;
         end
      end

      so_oe_d = !cs_n_s && (state_d == ST_ARG) && (opc_d == STATUS_READ_OP);
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
      begin
         sck_prev_q <= 1'b0;
         cs_prev_q  <= 1'b1;
         state_q    <= ST_IDLE;
         bitcnt_q   <= 3'h0;
         shift_q    <= 8'h00;
         opc_q      <= 8'h00;
         data_q     <= 8'h00;
         nbytes_q   <= 2'h0;
         out_q      <= STATUS_RESET;
         stat_q     <= STATUS_RESET;
         so_q       <= 1'b0;
         so_oe_q    <= 1'b0;
         start_q    <= 1'b0;
         code_q     <= 8'h00;
         susp_q     <= 1'b0;
         abort_q    <= 1'b0;
      end
      else
      begin
         sck_prev_q <= sck_s;
         cs_prev_q  <= cs_n_s;
         state_q    <= state_d;
         bitcnt_q   <= bitcnt_d;
         shift_q    <= shift_d;
         opc_q      <= opc_d;
         data_q     <= data_d;
         nbytes_q   <= nbytes_d;
         out_q      <= out_d;
         stat_q     <= stat_d;
         so_q       <= so_d;
         so_oe_q    <= so_oe_d;
         start_q    <= start_d;
         code_q     <= code_d;
         susp_q     <= susp_d;
         abort_q    <= abort_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign SO            = so_q;
   assign SO_OE         = so_oe_q;
   assign OP_START      = start_q;
   assign OP_CODE       = code_q;
   assign OP_SUSPEND    = susp_q;
   assign OP_ABORT      = abort_q;
   assign QUAD_LINES_ON = stat_q.quad_lines_enable;
   assign STATUS        = stat_q;

endmodule // fsw_status_write_enable

// ---- rtl/fsw_sync.sv ----
// two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module fsw_sync
   import fsw_pkg::*;
#(
   parameter int          WIDTH     = 4,
   parameter logic [3:0]  RESET_VAL = 4'h0
)
(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] stage_q;

   initial
   begin
      if (WIDTH < 1 || WIDTH > 4 || SYNC_STAGES != 2)
      begin
         $error("fsw_sync: unsupported width");
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta_q  <= RESET_VAL[WIDTH-1:0];
         stage_q <= RESET_VAL[WIDTH-1:0];
      end
      else
      begin
         meta_q  <= async_in;
         stage_q <= meta_q;
      end
   end

   assign sync_out = stage_q;

endmodule // fsw_sync

// ---- tb/fsw_host_model.sv ----
// host serial controller model: chip select, mode 0 clock and data
`timescale 1ns/1ps
module fsw_host_model
(
   input  wire logic CLK_SYS,
   input  wire logic SO,
   input  wire logic SO_OE,
   output logic      CS_N,
   output logic      SCK,
   output logic      SI
);
   // ----------------------------------------------------------------
   // frame driver
   // ----------------------------------------------------------------
   initial
   begin
      CS_N = 1'b1;
      SCK  = 1'b0;
      SI   = 1'b0;
   end

   // idle data line toggles so a stale level is never mistaken for data;
   // non-blocking on the edge so the first bit of a frame always wins
   always @(posedge CLK_SYS)
      if (CS_N)
         SI <= ~SI;

   task automatic xfer(input logic [7:0] op, input logic [7:0] dat, input int nbits,
                       output logic [15:0] rd);
      rd = 16'h0000;
      @(posedge CLK_SYS);
      #1 CS_N = 1'b0;
      for (int i = 0; i < nbits; i++)
      begin
         SI = (i < 8) ? op[7-i] : dat[7-(i%8)];
         repeat (4) @(posedge CLK_SYS);
         #1 SCK = 1'b1;
         repeat (4) @(posedge CLK_SYS);
         // sampled late in the high phase; undriven output reads unknown
         #1 rd = {rd[14:0], SO_OE ? SO : 1'bx};
         SCK = 1'b0;
      end
      repeat (4) @(posedge CLK_SYS);
      #1 CS_N = 1'b1;
   endtask

   task automatic armed_xfer(input logic [7:0] op, input logic [7:0] dat, input int nbits,
                             output logic [15:0] rd);
      xfer(8'h06, 8'h00, 8, rd);
      repeat (6) @(posedge CLK_SYS);
      xfer(op, dat, nbits, rd);
   endtask
endmodule // fsw_host_model

// ---- tb/fsw_status_write_enable_tb.sv ----
// random and corner-case bench for the status word block
`timescale 1ns/1ps
module fsw_status_write_enable_tb;
   logic        clk_sys = 1'b0;
   logic        rst     = 1'b1;
   logic        wp_n    = 1'b1;
   logic        op_done = 1'b0;
   logic        cs_n, sck, si, so, so_oe, op_start, op_suspend, op_abort, quad_on;
   logic [7:0]  op_code, status, d, exp_st;
   logic [15:0] rd;
   int          errors = 0, checks_done = 0, cycles = 0, seed = 8769;
   int          n_start = 0, n_susp = 0, n_abort = 0, exp_start = 0;
   logic [7:0]  gated_ops [30] = '{8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3e, 8'hd7, 8'h20,
      8'h21, 8'h52, 8'h5c, 8'hd8, 8'hdc, 8'hc7, 8'h60, 8'h01, 8'h42, 8'h65, 8'h85, 8'h64,
      8'h62, 8'h15, 8'h18, 8'hfd, 8'he3, 8'he4, 8'h2f, 8'ha6, 8'h91, 8'he8};

   // ----------------------------------------------------------------
   // clock, pulse counters, hang guard
   // ----------------------------------------------------------------
   always #25 clk_sys = ~clk_sys;

   always @(negedge clk_sys)
   begin
      cycles++;
      n_start += (op_start === 1'b1);
      n_susp  += (op_suspend === 1'b1);
      n_abort += (op_abort === 1'b1);
      if (cycles == 60000)
      begin
         errors++;
         tally_and_finish();
      end
   end

   fsw_status_write_enable DUT
   (
      .CLK_SYS       (clk_sys),
      .RST           (rst),
      .CS_N          (cs_n),
      .SCK           (sck),
      .SI            (si),
      .WP_N          (wp_n),
      .OP_DONE       (op_done),
      .SO            (so),
      .SO_OE         (so_oe),
      .OP_START      (op_start),
      .OP_CODE       (op_code),
      .OP_SUSPEND    (op_suspend),
      .OP_ABORT      (op_abort),
      .QUAD_LINES_ON (quad_on),
      .STATUS        (status)
   );

   fsw_host_model host
   (
      .CLK_SYS (clk_sys),
      .SO      (so),
      .SO_OE   (so_oe),
      .CS_N    (cs_n),
      .SCK     (sck),
      .SI      (si)
   );

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         errors++;
         $display("[ERR] %0t mismatch: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      if (errors == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   function automatic logic gated(input logic [7:0] op);
      gated = 1'b0;
      foreach (gated_ops[k])
         if (gated_ops[k] == op)
            gated = 1'b1;
   endfunction

   function automatic logic sw_ok(input logic [7:0] st, input logic wp);
      return !(st[7] && !wp && !st[6]);
   endfunction

   task automatic frame(input logic [7:0] op, input logic [7:0] dat, input int nbits,
                        input logic arm);
      if (arm)
         host.armed_xfer(op, dat, nbits, rd);
      else
         host.xfer(op, dat, nbits, rd);
      repeat (8) @(posedge clk_sys);
      #1;
   endtask

   task automatic finish_op();
      op_done = 1'b1;
      @(posedge clk_sys);
      #1 op_done = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
   endtask

   task automatic sw(input logic [7:0] dat);
      frame(8'h01, dat, 16, 1'b1);
      if (sw_ok(exp_st, wp_n))
      begin
         exp_start++;
         chk(status, {dat[7:2], 2'b11});
         finish_op();
         exp_st = {dat[7:2], 2'b00};
      end
      else
      begin
         chk(status, exp_st | 8'h02);
         frame(8'h04, 8'h00, 8, 1'b0);
      end
      chk(status, exp_st);
      chk(8'(n_start), 8'(exp_start));
      frame(8'h05, 8'h00, 24, 1'b0);
      chk(rd[15:8], exp_st);
      chk(rd[7:0], exp_st);
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (2) @(posedge clk_sys);
      #1 rst = 1'b0;
      repeat (4) @(posedge clk_sys);
      #1;
      chk(status, 8'h00);
      foreach (gated_ops[k])
      begin
         frame(gated_ops[k], 8'h00, 16, 1'b0);
         chk(status, 8'h00);
         frame(gated_ops[k], 8'h00, 16, 1'b1);
         exp_start++;
         chk(8'(n_start), 8'(exp_start));
         chk(op_code, gated_ops[k]);
         chk(status, 8'h03);
         d = gated_ops[$unsigned($random(seed)) % 30];
         frame(d, 8'h00, 16, 1'b0);
         frame(8'h04, 8'h00, 8, 1'b0);
         chk(8'(n_start), 8'(exp_start));
         frame(8'h05, 8'h00, 24, 1'b0);
         chk(rd[15:8], 8'h03);
         chk(rd[7:0], 8'h03);
         finish_op();
         chk(status, 8'h00);
      end
      frame(8'h02, 8'h00, 16, 1'b1);
      exp_start++;
      frame(8'h75, 8'h00, 8, 1'b0);
      frame(8'h81, 8'h00, 16, 1'b0);
      chk(status, 8'h03);
      chk(8'(n_start), 8'(exp_start));
      frame(8'h99, 8'h00, 8, 1'b0);
      chk(8'(n_susp), 8'h01);
      chk(8'(n_abort), 8'h01);
      chk(status, 8'h00);
      frame(8'h06, 8'h00, 5, 1'b0);
      chk(status, 8'h00);
      frame(8'h06, 8'h00, 8, 1'b0);
      chk(status, 8'h02);
      frame(8'h04, 8'h00, 8, 1'b0);
      chk(status, 8'h00);
      repeat (4)
      begin
         do
            d = 8'($random(seed));
         while (gated(d) || d inside {8'h05, 8'h81, 8'h06, 8'h04, 8'h99, 8'h75});
         frame(d, 8'h00, 16, 1'b0);
         exp_start++;
         chk(8'(n_start), 8'(exp_start));
         chk(status, 8'h00);
      end
      d = 8'($random(seed));
      exp_st = 8'h00;
      sw({2'b10, d[5:3], 1'b1, d[1:0]});
      frame(8'hc7, 8'h00, 16, 1'b1);
      chk(8'(n_start), 8'(exp_start));
      frame(8'h04, 8'h00, 8, 1'b0);
      wp_n = 1'b0;
      sw(8'h40);
      wp_n = 1'b1;
      sw(8'hc0);
      chk({7'h00, quad_on}, 8'h01);
      wp_n = 1'b0;
      sw(8'h40);
      rst = 1'b1;
      @(posedge clk_sys);
      #1 rst = 1'b0;
      repeat (4) @(posedge clk_sys);
      #1;
      chk(status, 8'h00);
      chk({7'h00, quad_on}, 8'h00);
      tally_and_finish();
   end
endmodule // fsw_status_write_enable_tb

// ---- tb/fsw_swe_asserts.sv ----
// concurrent checks on the top ports of the status word block
`timescale 1ns/1ps
module fsw_swe_asserts
   import fsw_pkg::*;
(
   input wire logic       CLK_SYS,
   input wire logic       RST,
   input wire logic       CS_N,
   input wire logic       OP_DONE,
   input wire logic       SO_OE,
   input wire logic       OP_START,
   input wire logic [7:0] OP_CODE,
   input wire logic       OP_SUSPEND,
   input wire logic       OP_ABORT,
   input wire logic       QUAD_LINES_ON,
   input wire logic [7:0] STATUS
);
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (RST);

   sequence sw_taken;
      OP_START && OP_CODE == STATUS_WRITE_CMD;
   endsequence

   sequence deselected;
      CS_N [*8];
   endsequence

   chk_reset_clear: assert property ($fell(RST) |-> STATUS == STATUS_RESET)
      else $error("status word not clear after reset");
   chk_quad_source: assert property ($changed(QUAD_LINES_ON) |-> sw_taken)
      else $error("quad enable changed without a status write");
   chk_busy_cause: assert property ($rose(STATUS[0]) |-> OP_START)
      else $error("busy rose without a started operation");
   chk_busy_drop: assert property (
      $fell(STATUS[0]) |-> $past(OP_DONE) || OP_ABORT || $past(OP_ABORT))
      else $error("busy fell without completion or reset");
   chk_done_clears: assert property (STATUS[0] && OP_DONE |=> STATUS[1:0] == 2'b00)
      else $error("completion left busy or latch set");
   chk_busy_refuse: assert property (STATUS[0] && $past(STATUS[0]) |-> !OP_START)
      else $error("instruction started while busy");
   chk_start_gated: assert property (
      OP_START && fsw_needs_wel(OP_CODE) |-> $past(STATUS[WEL_POS]))
      else $error("gated instruction started with latch clear");
   chk_erase_clear: assert property (
      OP_START && fsw_is_chip_erase(OP_CODE) |-> $past(STATUS[5:2]) == BLOCK_PROT_NONE)
      else $error("chip erase started with protect bits set");
   chk_sw_latch: assert property (sw_taken |-> STATUS[1:0] == 2'b11)
      else $error("status write changed latch or not busy");
   chk_suspend_busy: assert property (OP_SUSPEND |-> $past(STATUS[0]))
      else $error("suspend issued while not busy");
   chk_idle_release: assert property (deselected |-> !SO_OE)
      else $error("output driven while deselected");
endmodule // fsw_swe_asserts

bind fsw_status_write_enable fsw_swe_asserts u_chk
(
   .CLK_SYS       (CLK_SYS),
   .RST           (RST),
   .CS_N          (CS_N),
   .OP_DONE       (OP_DONE),
   .SO_OE         (SO_OE),
   .OP_START      (OP_START),
   .OP_CODE       (OP_CODE),
   .OP_SUSPEND    (OP_SUSPEND),
   .OP_ABORT      (OP_ABORT),
   .QUAD_LINES_ON (QUAD_LINES_ON),
   .STATUS        (STATUS)
);
